// ===== rtl/pmsmi_cfg.svh
// constants of the mac-side media interface: offsets, fields, timing
// assumes a 10 MHz pclk and includers that use the named macros only
//
// What this block does
// - tx bits 0 and 1 carry transmit data in both interface modes.
// - fault input at 100 Mb/s in full mode, outside symbol mode, replaces the encoded word by the /H/ code.
// - fault input is ignored at 10 Mb/s.
// - symbol mode: the fault pin is bit 4 of each 5-bit symbol.
// - reduced mode leaves tx bit 4, tx clock and rx bits 2, 3 unused.
// - tx valid marks valid data: four bits full mode, two bits reduced.
// - full mode drives a tx clock that times the capture of tx data.
// - rx data on four bits in full mode, on bits 0 and 1 in reduced.
// - interface strap low picks full mode, high picks reduced mode.
// - three operating mode straps share rx bits 0, 1 and collision.
// - three address straps share rx bit 3, rx fault and rx clock.
// - pending interrupts pull the shared open-drain pin low.
// - straps are sampled at reset and on a restrap write to ctrl, then held.
// - rx valid is high while decoded data sits on the rx bits.
// - rx fault is high when the passing frame holds an error.
// - reduced 10 Mb/s: rx bits stay low until the start delimiter.
`ifndef PMSMI_CFG_SVH
`define PMSMI_CFG_SVH

// ==========================================================
// register map
`define PMSMI_ADDR_CTRL    8'h00
`define PMSMI_ADDR_STRAP   8'h04
`define PMSMI_ADDR_STATUS  8'h08
`define PMSMI_ADDR_MASK    8'h0C
`define PMSMI_CTRL_SPEED   0
`define PMSMI_CTRL_SYMBOL  1
`define PMSMI_CTRL_RESTRAP 2
`define PMSMI_SPEED_RST    1'h1
`define PMSMI_STRAP_W      8
`define PMSMI_STRAP_DONE   8
`define PMSMI_EVT_W        4
`define PMSMI_EVT_TX_START 0
`define PMSMI_EVT_TX_ERR   1
`define PMSMI_EVT_RX_END   2
`define PMSMI_EVT_RX_ERR   3

// ==========================================================
// line coding
`define PMSMI_SYM_H     5'h04
`define PMSMI_SYM_W     7'h05
`define PMSMI_ENC_TABLE 80'hEF37_ABDA_727B_96AA_D13E
`define PMSMI_SFD       8'hAB

// ==========================================================
// timing
`define PMSMI_CLK_NS      100
`define PMSMI_SETTLE_NS   400
`define PMSMI_SETTLE_CYC  ((`PMSMI_SETTLE_NS + `PMSMI_CLK_NS - 1) / `PMSMI_CLK_NS)
`define PMSMI_SETTLE_LAST 3'(`PMSMI_SETTLE_CYC - 1)

`endif

// ===== rtl/pmsmi_pkg.sv
// types shared by the media interface modules
// assumes nothing beyond a systemverilog compiler
package pmsmi_pkg;

  typedef enum logic {PMSMI_SETTLE, PMSMI_RUN} pmsmi_strap_state_type;

  typedef struct packed {
    logic       irq_sel;
    logic [2:0] addr;
    logic [2:0] op_mode;
    logic       reduced;
  } pmsmi_strap_type;

  typedef struct packed {
    logic                      link;
    logic                      fault;
    logic                      valid;
    logic [3:0]                bits;
    pmsmi_strap_type           strap;
  } pmsmi_pins_type;

endpackage

// ===== rtl/pmsmi_tx_if.sv
// bundle between the top and the transmit capture module
// assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface pmsmi_tx_if;
  logic       cap;
  logic       reduced;
  logic       speed100;
  logic       symbol;
  logic       tx_valid;
  logic       fault;
  logic [3:0] bits;
  logic [4:0] code;
  logic       strobe;
  logic       active;
  logic       start_evt;
  logic       err_evt;

  modport ctl (output cap, reduced, speed100, symbol, tx_valid, fault, bits,
               input code, strobe, active, start_evt, err_evt);
  modport tx  (input cap, reduced, speed100, symbol, tx_valid, fault, bits,
               output code, strobe, active, start_evt, err_evt);
endinterface
`default_nettype wire

// ===== rtl/pmsmi_sync.sv
// two-flop synchroniser for a bundle of pin inputs
// assumes the inputs are asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module pmsmi_sync #(parameter int W = 1) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_meta = d;
    nxt_q    = meta_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= nxt_meta;
      q_ff    <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

// ===== rtl/pmsmi_tx.sv
// transmit capture: nibble assembly, 4b/5b coding, error substitution
// assumes cap is a one-cycle pulse per link clock rising edge
`timescale 1ns/1ps
`default_nettype none
`include "pmsmi_cfg.svh"
module pmsmi_tx (
  input  wire logic pclk,
  input  wire logic presetn,
  pmsmi_tx_if.tx    t
);
  localparam logic [79:0] ENC = `PMSMI_ENC_TABLE;

  logic       half_ff, nxt_half;
  logic [1:0] low_ff, nxt_low;
  logic       prev_ff, nxt_prev;
  logic [4:0] code_ff, nxt_code;
  logic       strobe_ff, nxt_strobe;
  logic       start_ff, nxt_start;
  logic       err_ff, nxt_err;

  // ==========================================================
  // capture and coding
  always_comb begin
    logic [3:0] nib;
    nib        = t.bits;
    nxt_half   = half_ff;
    nxt_low    = low_ff;
    nxt_prev   = prev_ff;
    nxt_code   = code_ff;
    nxt_strobe = 1'h0;
    nxt_start  = 1'h0;
    nxt_err    = 1'h0;
    if (t.cap) begin
      nxt_prev  = t.tx_valid;
      nxt_start = t.tx_valid & ~prev_ff;
      if (!t.tx_valid) begin
        nxt_half = 1'h0;
      end else if (t.reduced && !half_ff) begin
        nxt_half = 1'h1;
        nxt_low  = t.bits[1:0];
      end else begin
        nxt_half   = 1'h0;
        nib        = t.reduced ? {t.bits[1:0], low_ff} : t.bits;
        nxt_strobe = 1'h1;
        if (!t.speed100) begin
          nxt_code = {1'h0, nib};
        end else if (t.symbol && !t.reduced) begin
          nxt_code = {t.fault, nib};
        end else if (t.fault && !t.reduced) begin
          nxt_code = `PMSMI_SYM_H;
          nxt_err  = 1'h1;
        end else begin
          nxt_code = ENC[{3'h0, nib} * `PMSMI_SYM_W +: 5];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff   <= 1'h0;
      low_ff    <= 2'h0;
      prev_ff   <= 1'h0;
      code_ff   <= 5'h00;
      strobe_ff <= 1'h0;
      start_ff  <= 1'h0;
      err_ff    <= 1'h0;
    end else begin
      half_ff   <= nxt_half;
      low_ff    <= nxt_low;
      prev_ff   <= nxt_prev;
      code_ff   <= nxt_code;
      strobe_ff <= nxt_strobe;
      start_ff  <= nxt_start;
      err_ff    <= nxt_err;
    end
  end

  assign t.code      = code_ff;
  assign t.strobe    = strobe_ff;
  assign t.active    = prev_ff;
  assign t.start_evt = start_ff;
  assign t.err_evt   = err_ff;

  // ==========================================================
  // checks
  AST_TX_H: assert property (@(posedge pclk) disable iff (!presetn)
    (t.cap && t.tx_valid && t.speed100 && !t.symbol && !t.reduced && t.fault)
    |=> (strobe_ff && code_ff == `PMSMI_SYM_H && err_ff))
    else $error("error code not sent");
  AST_TX_10M: assert property (@(posedge pclk) disable iff (!presetn)
    (t.cap && t.tx_valid && !t.speed100 && !(t.reduced && !half_ff))
    |=> (!err_ff && !code_ff[4]))
    else $error("fault acted at 10 Mb/s");
  AST_TX_SYM: assert property (@(posedge pclk) disable iff (!presetn)
    (t.cap && t.tx_valid && t.speed100 && t.symbol && !t.reduced)
    |=> (strobe_ff && code_ff == {$past(t.fault), $past(t.bits)}))
    else $error("symbol bit 4 lost");
  AST_TX_PAIR: assert property (@(posedge pclk) disable iff (!presetn)
    (t.cap && t.tx_valid && t.reduced && !half_ff) |=> !strobe_ff)
    else $error("reduced half nibble emitted");
endmodule
`default_nettype wire

// ===== rtl/pmsmi_top.sv
// mac-facing media interface: straps, transmit capture, receive pins, apb
// assumes apb master on pclk; pins and link clock asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "pmsmi_cfg.svh"
module pmsmi_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        link_clk,
  input  wire logic        tx_bit0_in,
  input  wire logic        tx_bit1_in,
  input  wire logic        tx_bit2_in,
  input  wire logic        tx_bit3_in,
  input  wire logic        tx_valid_in,
  input  wire logic        tx_fault_in,
  output logic             irq_out_low,
  output logic             irq_out_low_oe_n,
  output logic             tx_ref_clock_out,
  input  wire logic        irq_pin_function_strap,
  input  wire logic        op_mode_strap_0,
  output logic             rx_bit0_out,
  output logic             rx_bit0_oe_n,
  input  wire logic        op_mode_strap_1,
  output logic             rx_bit1_out,
  output logic             rx_bit1_oe_n,
  input  wire logic        reduced_interface_strap,
  output logic             rx_bit2_out,
  output logic             rx_bit2_oe_n,
  input  wire logic        mgmt_addr_strap_0,
  output logic             rx_bit3_out,
  output logic             rx_bit3_oe_n,
  input  wire logic        mgmt_addr_strap_1,
  output logic             rx_fault_out,
  output logic             rx_fault_oe_n,
  input  wire logic        mgmt_addr_strap_2,
  output logic             rx_ref_clock_out,
  output logic             rx_ref_clock_oe_n,
  input  wire logic        op_mode_strap_2,
  output logic             carrier_valid_combined_out,
  output logic             carrier_valid_combined_oe_n,
  output logic             rx_valid_out,
  input  wire logic [3:0]  line_rx_nibble,
  input  wire logic        line_rx_valid,
  input  wire logic        line_rx_error,
  input  wire logic        line_rx_carrier,
  input  wire logic        line_collision,
  output logic      [4:0]  tx_line_code,
  output logic             tx_line_strobe,
  output logic             tx_line_active
);
  // ==========================================================
  // pin synchronisers
  pmsmi_pkg::pmsmi_pins_type raw;
  pmsmi_pkg::pmsmi_pins_type s;

  always_comb begin
    raw               = '0;
    raw.link          = link_clk;
    raw.fault         = tx_fault_in;
    raw.valid         = tx_valid_in;
    raw.bits          = {tx_bit3_in, tx_bit2_in, tx_bit1_in, tx_bit0_in};
    raw.strap.irq_sel = irq_pin_function_strap;
    raw.strap.addr    = {mgmt_addr_strap_2, mgmt_addr_strap_1, mgmt_addr_strap_0};
    raw.strap.op_mode = {op_mode_strap_2, op_mode_strap_1, op_mode_strap_0};
    raw.strap.reduced = reduced_interface_strap;
  end

  pmsmi_sync #(.W($bits(pmsmi_pkg::pmsmi_pins_type))) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (raw),
    .q       (s)
  );

  // ==========================================================
  // strap sampling
  pmsmi_pkg::pmsmi_strap_state_type state_ff, nxt_state;
  pmsmi_pkg::pmsmi_strap_type       strap_ff, nxt_strap;
  logic [2:0]                       cnt_ff, nxt_cnt;
  logic                             run;
  logic                             restrap;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_strap = strap_ff;
    case (state_ff)
      pmsmi_pkg::PMSMI_SETTLE: begin
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == `PMSMI_SETTLE_LAST) begin
          nxt_strap = s.strap;
          nxt_cnt   = 3'h0;
          nxt_state = pmsmi_pkg::PMSMI_RUN;
        end
      end
      pmsmi_pkg::PMSMI_RUN: begin
        if (restrap) begin
          nxt_state = pmsmi_pkg::PMSMI_SETTLE;
        end
      end
      default: begin
        nxt_state = pmsmi_pkg::PMSMI_SETTLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= pmsmi_pkg::PMSMI_SETTLE;
      cnt_ff   <= 3'h0;
      strap_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      strap_ff <= nxt_strap;
    end
  end

  assign run = (state_ff == pmsmi_pkg::PMSMI_RUN);

  // ==========================================================
  // apb registers and interrupt
  logic                    setup;
  logic                    access;
  logic                    hit;
  logic [31:0]             rmux;
  logic [31:0]             prdata_ff, nxt_prdata;
  logic                    speed_ff, nxt_speed;
  logic                    symbol_ff, nxt_symbol;
  logic [`PMSMI_EVT_W-1:0] mask_ff, nxt_mask;
  logic [`PMSMI_EVT_W-1:0] status_ff, nxt_status;
  logic [`PMSMI_EVT_W-1:0] set;
  logic [`PMSMI_EVT_W-1:0] clr;
  logic                    irq_ff, nxt_irq;

  assign setup  = psel & ~penable;
  assign access = psel & penable;

  always_comb begin
    rmux = 32'h0;
    hit  = 1'h1;
    case (paddr)
      `PMSMI_ADDR_CTRL: begin
        rmux[`PMSMI_CTRL_SPEED]  = speed_ff;
        rmux[`PMSMI_CTRL_SYMBOL] = symbol_ff;
      end
      `PMSMI_ADDR_STRAP: begin
        rmux[`PMSMI_STRAP_W-1:0] = strap_ff;
        rmux[`PMSMI_STRAP_DONE]  = run;
      end
      `PMSMI_ADDR_STATUS: rmux[`PMSMI_EVT_W-1:0] = status_ff;
      `PMSMI_ADDR_MASK:   rmux[`PMSMI_EVT_W-1:0] = mask_ff;
      default:            hit = 1'h0;
    endcase
  end

  assign restrap = access & pwrite & (paddr == `PMSMI_ADDR_CTRL)
                   & pwdata[`PMSMI_CTRL_RESTRAP];

  always_comb begin
    nxt_prdata = setup ? rmux : prdata_ff;
    nxt_speed  = speed_ff;
    nxt_symbol = symbol_ff;
    nxt_mask   = mask_ff;
    clr        = '0;
    if (access && pwrite && paddr == `PMSMI_ADDR_CTRL) begin
      nxt_speed  = pwdata[`PMSMI_CTRL_SPEED];
      nxt_symbol = pwdata[`PMSMI_CTRL_SYMBOL];
    end
    if (access && pwrite && paddr == `PMSMI_ADDR_MASK) begin
      nxt_mask = pwdata[`PMSMI_EVT_W-1:0];
    end
    if (access && !pwrite && paddr == `PMSMI_ADDR_STATUS) begin
      clr = prdata_ff[`PMSMI_EVT_W-1:0];
    end
    nxt_status = (status_ff & ~clr) | set;
    nxt_irq    = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      speed_ff  <= `PMSMI_SPEED_RST;
      symbol_ff <= 1'h0;
      mask_ff   <= '0;
      status_ff <= '0;
      irq_ff    <= 1'h0;
    end else begin
      prdata_ff <= nxt_prdata;
      speed_ff  <= nxt_speed;
      symbol_ff <= nxt_symbol;
      mask_ff   <= nxt_mask;
      status_ff <= nxt_status;
      irq_ff    <= nxt_irq;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'h1;
  assign pslverr = access & ~hit;
  assign irq     = irq_ff;

  // ==========================================================
  // transmit side
  pmsmi_tx_if u_if ();
  logic       edge_p;

  assign u_if.cap      = edge_p & run;
  assign u_if.reduced  = strap_ff.reduced;
  assign u_if.speed100 = speed_ff;
  assign u_if.symbol   = symbol_ff;
  assign u_if.tx_valid = s.valid;
  assign u_if.bits     = s.bits;
  assign u_if.fault    = s.fault & ~strap_ff.irq_sel;

  pmsmi_tx u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (u_if.tx)
  );

  assign tx_line_code   = u_if.code;
  assign tx_line_strobe = u_if.strobe;
  assign tx_line_active = u_if.active;

  // ==========================================================
  // receive side and link clock
  logic       link_prev_ff, nxt_link_prev;
  logic       clk_ff, nxt_clk;
  logic [3:0] rxd_ff, nxt_rxd;
  logic       rxv_ff, nxt_rxv;
  logic       rxe_ff, nxt_rxe;
  logic       cvc_ff, nxt_cvc;
  logic [7:0] sr_ff, nxt_sr;
  logic       sfd_ff, nxt_sfd;

  assign edge_p = s.link & ~link_prev_ff;

  always_comb begin
    logic [7:0] shifted;
    shifted       = {line_rx_nibble[1:0], sr_ff[7:2]};
    nxt_link_prev = s.link;
    nxt_clk       = run & ~strap_ff.reduced & s.link;
    nxt_rxd       = rxd_ff;
    nxt_rxv       = rxv_ff;
    nxt_rxe       = rxe_ff;
    nxt_cvc       = cvc_ff;
    nxt_sr        = sr_ff;
    nxt_sfd       = sfd_ff;
    if (!run) begin
      nxt_rxd = 4'h0;
      nxt_rxv = 1'h0;
      nxt_rxe = 1'h0;
      nxt_cvc = 1'h0;
      nxt_sr  = 8'h00;
      nxt_sfd = 1'h0;
    end else if (edge_p) begin
      nxt_rxv = line_rx_valid;
      nxt_rxe = line_rx_error & line_rx_valid;
      if (strap_ff.reduced) begin
        nxt_cvc = line_rx_carrier | line_rx_valid;
        nxt_sr  = line_rx_carrier ? shifted : 8'h00;
        nxt_sfd = line_rx_carrier & (sfd_ff | (shifted == `PMSMI_SFD));
        nxt_rxd = (speed_ff | sfd_ff) ? {2'h0, line_rx_nibble[1:0]} : 4'h0;
      end else begin
        nxt_cvc = line_collision;
        nxt_rxd = line_rx_nibble;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_prev_ff <= 1'h0;
      clk_ff       <= 1'h0;
      rxd_ff       <= 4'h0;
      rxv_ff       <= 1'h0;
      rxe_ff       <= 1'h0;
      cvc_ff       <= 1'h0;
      sr_ff        <= 8'h00;
      sfd_ff       <= 1'h0;
    end else begin
      link_prev_ff <= nxt_link_prev;
      clk_ff       <= nxt_clk;
      rxd_ff       <= nxt_rxd;
      rxv_ff       <= nxt_rxv;
      rxe_ff       <= nxt_rxe;
      cvc_ff       <= nxt_cvc;
      sr_ff        <= nxt_sr;
      sfd_ff       <= nxt_sfd;
    end
  end

  always_comb begin
    set                      = '0;
    set[`PMSMI_EVT_TX_START] = u_if.start_evt;
    set[`PMSMI_EVT_TX_ERR]   = u_if.err_evt;
    set[`PMSMI_EVT_RX_END]   = edge_p & run & rxv_ff & ~line_rx_valid;
    set[`PMSMI_EVT_RX_ERR]   = edge_p & run & line_rx_error & line_rx_valid;
  end

  // ==========================================================
  // pin drivers
  assign tx_ref_clock_out            = clk_ff;
  assign rx_ref_clock_out            = clk_ff;
  assign rx_bit0_out                 = rxd_ff[0];
  assign rx_bit1_out                 = rxd_ff[1];
  assign rx_bit2_out                 = rxd_ff[2];
  assign rx_bit3_out                 = rxd_ff[3];
  assign rx_fault_out                = rxe_ff;
  assign rx_valid_out                = rxv_ff;
  assign carrier_valid_combined_out  = cvc_ff;
  assign rx_bit0_oe_n                = ~run;
  assign rx_bit1_oe_n                = ~run;
  assign rx_bit2_oe_n                = ~run | strap_ff.reduced;
  assign rx_bit3_oe_n                = ~run | strap_ff.reduced;
  assign rx_fault_oe_n               = ~run;
  assign rx_ref_clock_oe_n           = ~run | strap_ff.reduced;
  assign carrier_valid_combined_oe_n = ~run;
  assign irq_out_low                 = 1'h0;
  assign irq_out_low_oe_n            = ~(irq_ff & strap_ff.irq_sel & run);

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_STRAP_HOLD: assert property ((run && $past(run)) |-> $stable(strap_ff))
    else $error("straps changed while running");
  AST_MODE_LATCH: assert property ($rose(run) |->
    strap_ff.reduced == $past(s.strap.reduced))
    else $error("interface strap not latched");
  AST_OPMODE_LATCH: assert property ($rose(run) |->
    strap_ff.op_mode == $past(s.strap.op_mode))
    else $error("mode straps not latched");
  AST_ADDR_LATCH: assert property ($rose(run) |->
    strap_ff.addr == $past(s.strap.addr))
    else $error("address straps not latched");
  AST_PINS_OFF: assert property (!run |-> (rx_bit0_oe_n && rx_bit1_oe_n
    && rx_bit2_oe_n && rx_bit3_oe_n && rx_fault_oe_n && rx_ref_clock_oe_n
    && carrier_valid_combined_oe_n))
    else $error("shared pin driven during strap sampling");
  AST_REDUCED_IDLE: assert property ((run && strap_ff.reduced) |=>
    (rx_bit2_oe_n && rx_bit3_oe_n && !tx_ref_clock_out))
    else $error("unused pin active in reduced mode");
  AST_SFD_GATE: assert property ((edge_p && run && strap_ff.reduced && !speed_ff
    && !sfd_ff) |=> rxd_ff == 4'h0)
    else $error("rx bits before start delimiter");
  AST_IRQ_PIN: assert property ((irq_ff && strap_ff.irq_sel && run) |->
    (!irq_out_low_oe_n && !irq_out_low))
    else $error("interrupt pin not pulled low");
  AST_RX_VALID: assert property ((edge_p && run) |=>
    rx_valid_out == $past(line_rx_valid))
    else $error("rx valid does not follow line");
endmodule
`default_nettype wire

// ===== verif/pmsmi_mac_model.sv
// mac transmit model: puts a nibble on the tx pins at each link clock fall
// assumes pclk samples link_clk; bench sets nib, en and err
`timescale 1ns/1ps
`default_nettype none
module pmsmi_mac_model (
  input  wire logic       pclk,
  input  wire logic       link_clk,
  input  wire logic       reduced,
  input  wire logic [3:0] nib,
  input  wire logic       en,
  input  wire logic       err,
  output logic      [3:0] txd,
  output logic            tx_en,
  output logic            tx_err
);
  logic lk_q;
  initial begin
    lk_q = 1'b0;
    txd = 4'h0;
    tx_en = 1'b0;
    tx_err = 1'b0;
  end
  always @(posedge pclk) begin
    lk_q <= link_clk;
    if (lk_q && !link_clk) begin
      txd <= reduced ? {2'b00, nib[1:0]} : nib;
      tx_en <= en;
      tx_err <= err;
    end
  end
endmodule
`default_nettype wire

// ===== verif/pmsmi_top_tb.sv
// self-checking bench of the mac-side media interface
// assumes the mac model file and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module pmsmi_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, link_clk = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, irq, er, irq_out_low, irq_out_low_oe_n, tx_ref_clock_out;
  logic [6:0] sv = 7'h59;
  wire logic [6:0] so, soe;
  logic irq_strap = 0, m_en = 0, m_err = 0, mten, merr, lv = 0, le = 0;
  logic [3:0] m_nib = 0, mtx, ln = 0;
  logic rxv, lt, ls;
  logic [4:0] code;
  int fail_count = 0, n_compared = 0;
  wire logic [6:0] sp = (sv & soe) | (so & ~soe);
  wire logic fpin = irq_out_low_oe_n ? merr : irq_out_low;
  always #50 pclk = ~pclk;
  initial begin
    #13;
    forever #400 link_clk = ~link_clk;
  end
  pmsmi_mac_model pmsmi_mac_model_i (.pclk, .link_clk, .reduced(sv[2]), .nib(m_nib),
    .en(m_en), .err(m_err), .txd(mtx), .tx_en(mten), .tx_err(merr));
  pmsmi_top pmsmi_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .link_clk, .tx_bit0_in(mtx[0]), .tx_bit1_in(mtx[1]),
    .tx_bit2_in(mtx[2]), .tx_bit3_in(mtx[3]), .tx_valid_in(mten), .tx_fault_in(fpin),
    .irq_out_low, .irq_out_low_oe_n, .tx_ref_clock_out, .irq_pin_function_strap(irq_strap),
    .op_mode_strap_0(sp[0]), .rx_bit0_out(so[0]), .rx_bit0_oe_n(soe[0]),
    .op_mode_strap_1(sp[1]), .rx_bit1_out(so[1]), .rx_bit1_oe_n(soe[1]),
    .reduced_interface_strap(sp[2]), .rx_bit2_out(so[2]), .rx_bit2_oe_n(soe[2]),
    .mgmt_addr_strap_0(sp[3]), .rx_bit3_out(so[3]), .rx_bit3_oe_n(soe[3]),
    .mgmt_addr_strap_1(sp[4]), .rx_fault_out(so[4]), .rx_fault_oe_n(soe[4]),
    .mgmt_addr_strap_2(sp[5]), .rx_ref_clock_out(so[5]), .rx_ref_clock_oe_n(soe[5]),
    .op_mode_strap_2(sp[6]), .carrier_valid_combined_out(so[6]),
    .carrier_valid_combined_oe_n(soe[6]), .rx_valid_out(rxv), .line_rx_nibble(ln),
    .line_rx_valid(lv), .line_rx_error(le), .line_rx_carrier(lv), .line_collision(le),
    .tx_line_code(code), .tx_line_strobe(ls), .tx_line_active(lt));
  // ==========================================================
  // shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_tx(input logic [3:0] n, input logic f, input logic [4:0] exp);
    int k;
    m_nib <= n;
    m_err <= f;
    m_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (ls !== 1'b1 && k < 100);
      if (ls !== 1'b1) fail_count++;
    end
    cmp({26'h0, lt, code}, {26'h0, 1'b1, exp});
    $display("test tx done");
  endtask
  task automatic t_clk(input logic exp);
    logic [1:0] seen;
    seen = 2'h0;
    repeat (20) begin
      @(posedge pclk);
      seen = seen | {so[5], tx_ref_clock_out};
    end
    cmp({30'h0, seen}, {30'h0, exp, exp});
    $display("test clock done");
  endtask
  task automatic t_sfd();
    logic [17:0] seq;
    seq = 18'h1_AB55;
    lv <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(posedge link_clk);
      @(posedge pclk);
      if (i > 0) cmp({30'h0, so[1:0]}, 32'h0);
      ln <= {2'h0, seq[2*i +: 2]};
    end
    @(posedge link_clk);
    @(posedge pclk);
    cmp({29'h0, so[6], so[1:0]}, 32'h0000_0005);
    lv <= 1'b0;
    $display("test sfd done");
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    cmp({25'h0, soe}, 32'h0000_007F);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    cmp(rd, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    cmp(rd, 32'h0000_013A);
    apb(1'b0, 8'h10, 32'h0);
    cmp({31'h0, er}, 32'h0000_0001);
    t_clk(1'b1);
    t_tx(4'h5, 1'b0, 5'h0B);
    t_tx(4'h5, 1'b1, 5'h04);
    apb(1'b1, 8'h00, 32'h0);
    t_tx(4'h5, 1'b1, 5'h05);
    apb(1'b1, 8'h00, 32'h0000_0003);
    t_tx(4'h5, 1'b1, 5'h15);
    m_en <= 1'b0;
    m_err <= 1'b0;
    ln <= 4'hA;
    lv <= 1'b1;
    le <= 1'b1;
    repeat (24) @(posedge pclk);
    cmp({24'h0, lt, so[6], so[4], rxv, so[3:0]}, 32'h0000_007A);
    lv <= 1'b0;
    le <= 1'b0;
    apb(1'b1, 8'h0C, 32'h0000_0001);
    @(posedge pclk);
    cmp({30'h0, irq, irq_out_low_oe_n}, 32'h0000_0003);
    apb(1'b0, 8'h08, 32'h0);
    cmp(rd & 32'h0000_0001, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    cmp({31'h0, irq}, 32'h0);
    sv <= 7'h5D;
    irq_strap <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000_0005);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    cmp(rd, 32'h0000_01BB);
    t_clk(1'b0);
    m_en <= 1'b1;
    repeat (40) @(posedge pclk);
    cmp({29'h0, irq, irq_out_low_oe_n, irq_out_low}, 32'h0000_0004);
    apb(1'b1, 8'h00, 32'h0);
    t_sfd();
    test_done();
  end
  initial begin
    #3_000_000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
